// ---- rtl/vfis_pkg.sv ----
package vfis_pkg;
  // Register word indices (byte address divided by four)
  localparam logic [3:0] VFIS_IDX_CTRL = 4'h0;
  localparam logic [3:0] VFIS_IDX_VWIN = 4'h1;
  localparam logic [3:0] VFIS_IDX_HWIN = 4'h2;
  localparam logic [3:0] VFIS_IDX_STATUS = 4'h3;
  localparam logic [3:0] VFIS_IDX_STILL_OUT = 4'h4;
  localparam logic [3:0] VFIS_IDX_STILL_IN = 4'h5;
  localparam int VFIS_ADDR_W = 6;

  // Control register field positions
  localparam int VFIS_CTRL_MODE_LSB = 0;
  localparam int VFIS_CTRL_SYNC_INT = 3;
  localparam int VFIS_CTRL_EXT_FIELD = 4;
  localparam int VFIS_CTRL_TOP_SENSE = 5;
  localparam int VFIS_CTRL_HS_POL = 6;
  localparam int VFIS_CTRL_VS_POL = 7;
  localparam int VFIS_CTRL_QUAL_POL = 8;
  localparam int VFIS_CTRL_W = 9;
  // Top field sense defaults to 1, everything else off
  localparam logic [8:0] VFIS_CTRL_RESET = 9'h020;

  // Window registers: first offset in [9:0], last offset in [25:16]
  localparam int VFIS_CNT_W = 10;
  localparam int VFIS_WIN_LAST_LSB = 16;
  localparam logic [9:0] VFIS_CNT_MAX = 10'h3FF;
  localparam logic [9:0] VFIS_WIN_FIRST_RESET = 10'h000;
  localparam logic [9:0] VFIS_WIN_LAST_RESET = 10'h3FF;

  // Status register field positions
  localparam int VFIS_STAT_LINE_LSB = 0;
  localparam int VFIS_STAT_FIELD = 16;
  localparam int VFIS_STAT_OVF = 17;

  // Stream word: {field, chroma, luma}
  localparam int VFIS_PIX_W = 8;
  localparam int VFIS_EXT_W = 24;
  localparam int VFIS_WORD_W = 17;
  localparam int VFIS_BUF_DEPTH = 2;

  // Pin vector layout after the synchroniser
  localparam int VFIS_PIN_W = 29;

  typedef enum logic [2:0] {
    VFIS_MODE_IDLE = 3'b000,
    VFIS_MODE_MOTION_COMP = 3'b001,
    VFIS_MODE_MOTION_DECOMP = 3'b010,
    VFIS_MODE_MPEG = 3'b011,
    VFIS_MODE_STILL_COMP = 3'b100,
    VFIS_MODE_STILL_DECOMP = 3'b101
  } vfis_mode_e;
endpackage

// ---- rtl/vfis_sampler.sv ----
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
module vfis_sampler (
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [vfis_pkg::VFIS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Video pins
  input wire logic double_rate_pixel_clock,
  input wire logic pixel_clock_qualifier,
  input wire logic [vfis_pkg::VFIS_PIX_W-1:0] luma_bus,
  input wire logic [vfis_pkg::VFIS_PIX_W-1:0] chroma_bus,
  input wire logic [vfis_pkg::VFIS_PIX_W-1:0] ext_bus_hi_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic field_indicator_input,
  output logic hsync_out,
  output logic hsync_oe_n,
  output logic vsync_out,
  output logic vsync_oe_n,
  output logic [vfis_pkg::VFIS_EXT_W-1:0] ext_bus_out,
  output logic ext_bus_oe_n,
  // Internal sync generator levels, same clock domain
  input wire logic gen_hsync,
  input wire logic gen_vsync,
  // Stream towards the video input processor
  output logic [vfis_pkg::VFIS_WORD_W-1:0] stream_data,
  output logic stream_valid,
  input wire logic stream_ready
);
  import vfis_pkg::*;

  // Register window test on the counters
  // Bounds are inclusive at both ends, so first equal to last keeps one
  function automatic logic in_range(input logic [9:0] v, input logic [9:0] lo,
                                    input logic [9:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Edge of a sync line seen from the chosen active polarity
  // Polarity one makes the falling edge the active one
  function automatic logic active_edge(input logic now, input logic prev, input logic pol);
    active_edge = pol ? (prev && !now) : (!prev && now);
  endfunction

  // ---------------- Pin synchroniser ----------------
  // Every video pin is asynchronous to clk_sys; the double-rate clock is
  // treated as data and its edges are found after two flops
  // Limitation: the link clock must stay well below half of clk_sys,
  // or edges merge and samples are missed
  logic [VFIS_PIN_W-1:0] pin_s1_reg, pin_s2_reg;
  logic [VFIS_PIN_W-1:0] pin_raw;
  assign pin_raw = {double_rate_pixel_clock, pixel_clock_qualifier, field_indicator_input,
                    vsync_in, hsync_in, ext_bus_hi_in, chroma_bus, luma_bus};

  // Two flops on every pin; only stage two is read downstream
  always_ff @(posedge clk_sys) begin
    pin_s1_reg <= pin_raw;
    pin_s2_reg <= pin_s1_reg;
  end

  // Stage-two view of the pins, split back into their fields
  logic drclk_s, qual_s, fi_s, vs_s, hs_s;
  logic [7:0] luma_s, chroma_s, hi_s;
  assign {drclk_s, qual_s, fi_s, vs_s, hs_s, hi_s, chroma_s, luma_s} = pin_s2_reg;

  // ---------------- Registers ----------------
  // Control fields are decoded once here and read everywhere below
  logic [VFIS_CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [31:0] vwin_reg, vwin_next, hwin_reg, hwin_next;
  logic [23:0] still_out_reg, still_out_next;
  logic [23:0] still_in_reg, still_in_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic ovf_reg, ovf_next;

  vfis_mode_e mode;
  logic sync_int_sel, ext_field, top_sense, hs_pol, vs_pol, qual_pol;
  logic [9:0] first_line, last_line, first_pix, last_pix;
  assign mode = vfis_mode_e'(ctrl_reg[VFIS_CTRL_MODE_LSB +: 3]);
  assign sync_int_sel = ctrl_reg[VFIS_CTRL_SYNC_INT];
  assign ext_field = ctrl_reg[VFIS_CTRL_EXT_FIELD];
  assign top_sense = ctrl_reg[VFIS_CTRL_TOP_SENSE];
  assign hs_pol = ctrl_reg[VFIS_CTRL_HS_POL];
  assign vs_pol = ctrl_reg[VFIS_CTRL_VS_POL];
  assign qual_pol = ctrl_reg[VFIS_CTRL_QUAL_POL];
  assign first_line = vwin_reg[9:0];
  assign last_line = vwin_reg[VFIS_WIN_LAST_LSB +: VFIS_CNT_W];
  assign first_pix = hwin_reg[9:0];
  assign last_pix = hwin_reg[VFIS_WIN_LAST_LSB +: VFIS_CNT_W];

  // ---------------- Sampling core ----------------
  // Sample-rate state; only a qualified rise may change the counters, field and samples
  logic drclk_d_reg, drclk_d_next;
  logic hs_d_reg, hs_d_next, vs_d_reg, vs_d_next;
  logic [9:0] pix_cnt_reg, pix_cnt_next, line_cnt_reg, line_cnt_next;
  logic top_reg, top_next;
  logic [7:0] luma_reg, luma_next, chroma_reg, chroma_next;
  logic win_reg, win_next;
  logic smp_reg, smp_next;
  logic hs_out_reg, hs_out_next, vs_out_reg, vs_out_next;
  logic rise_en, fall_en, hs_edge, vs_edge;
  logic fwd_mode, still_mode, drive_sync, int_sync;

  // Rising edge of the double-rate clock, qualifier in the chosen phase
  assign rise_en = drclk_s && !drclk_d_reg && (qual_s == qual_pol);
  assign fall_en = !drclk_s && drclk_d_reg && (qual_s == qual_pol);
  // Sync edges compare each sample with the previous sample, not the raw pin,
  // so junk between qualified edges cannot fake an edge
  assign hs_edge = active_edge(hs_s, hs_d_reg, hs_pol);
  assign vs_edge = active_edge(vs_s, vs_d_reg, vs_pol);
  assign still_mode = (mode == VFIS_MODE_STILL_COMP) || (mode == VFIS_MODE_STILL_DECOMP);
  assign fwd_mode = (mode == VFIS_MODE_MOTION_COMP) || (mode == VFIS_MODE_MOTION_DECOMP)
                    || (mode == VFIS_MODE_MPEG);
  // Internal sync only honoured in motion decompression; motion compression and MPEG stay external
  assign int_sync = sync_int_sel && (mode == VFIS_MODE_MOTION_DECOMP);
  assign drive_sync = int_sync || still_mode;

  // Counters, field and window decision, one step per qualified rise
  // The window test uses the next counts so the flag lines up with the
  // registered pixel that it qualifies
  always_comb begin
    drclk_d_next = drclk_s;
    hs_d_next = hs_d_reg;
    vs_d_next = vs_d_reg;
    pix_cnt_next = pix_cnt_reg;
    line_cnt_next = line_cnt_reg;
    top_next = top_reg;
    luma_next = luma_reg;
    chroma_next = chroma_reg;
    win_next = win_reg;
    smp_next = 1'b0;
    if (rise_en) begin
      hs_d_next = hs_s;
      vs_d_next = vs_s;
      luma_next = luma_s;
      chroma_next = chroma_s;
      // Pixel count restarts at the active hsync edge and saturates at VFIS_CNT_MAX
      if (hs_edge) begin
        pix_cnt_next = 10'h000;
      end else if (pix_cnt_reg != VFIS_CNT_MAX) begin
        pix_cnt_next = pix_cnt_reg + 10'h001;
      end
      if (vs_edge) begin
        line_cnt_next = 10'h000;
      end else if (hs_edge && line_cnt_reg != VFIS_CNT_MAX) begin
        line_cnt_next = line_cnt_reg + 10'h001;
      end
      if (ext_field) begin
        top_next = (fi_s == top_sense);
      end else if (vs_edge) begin
        top_next = (hs_s == top_sense);
      end
      win_next = in_range(line_cnt_next, first_line, last_line)
                 && in_range(pix_cnt_next, first_pix, last_pix);
      smp_next = 1'b1;
    end
  end

  // Sampler state; edge history restarts low to match an idle pin,
  // so no false edge follows reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      drclk_d_reg <= 1'b0;
      hs_d_reg <= 1'b0;
      vs_d_reg <= 1'b0;
      pix_cnt_reg <= 10'h000;
      line_cnt_reg <= 10'h000;
      top_reg <= 1'b0;
      luma_reg <= 8'h00;
      chroma_reg <= 8'h00;
      win_reg <= 1'b0;
      smp_reg <= 1'b0;
    end else begin
      drclk_d_reg <= drclk_d_next;
      hs_d_reg <= hs_d_next;
      vs_d_reg <= vs_d_next;
      pix_cnt_reg <= pix_cnt_next;
      line_cnt_reg <= line_cnt_next;
      top_reg <= top_next;
      luma_reg <= luma_next;
      chroma_reg <= chroma_next;
      win_reg <= win_next;
      smp_reg <= smp_next;
    end
  end

  // Sync drive: levels launched on qualified falling edges only
  always_comb begin
    hs_out_next = hs_out_reg;
    vs_out_next = vs_out_reg;
    if (fall_en) begin
      hs_out_next = gen_hsync;
      vs_out_next = gen_vsync;
    end
  end

  // Generated sync levels, cleared so nothing toggles before the first fall
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hs_out_reg <= 1'b0;
      vs_out_reg <= 1'b0;
    end else begin
      hs_out_reg <= hs_out_next;
      vs_out_reg <= vs_out_next;
    end
  end

  // Pin drive; oe_n low means this side owns the line
  // Motion compression and MPEG never drive sync, so the source keeps it
  assign hsync_out = hs_out_reg;
  assign vsync_out = vs_out_reg;
  assign hsync_oe_n = !drive_sync;
  assign vsync_oe_n = !drive_sync;
  assign ext_bus_out = still_out_reg;
  assign ext_bus_oe_n = (mode != VFIS_MODE_STILL_COMP);

  // ---------------- Two-entry stream buffer ----------------
  logic [VFIS_WORD_W-1:0] buf_mem [VFIS_BUF_DEPTH];
  logic [VFIS_WORD_W-1:0] buf_mem_next [VFIS_BUF_DEPTH];
  logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0] cnt_reg, cnt_next;
  logic push, pop, buf_ready, take_word;

  // A full buffer still takes a word in the cycle in which the receiver pops
  // one, so only a stall across two whole samples loses anything
  assign buf_ready = (cnt_reg != 2'd2) || stream_ready;
  // A sample that belongs in the stream, whether or not there is room for it
  assign take_word = smp_reg && win_reg && fwd_mode;
  assign push = take_word && buf_ready;
  assign pop = stream_valid && stream_ready;
  assign stream_valid = (cnt_reg != 2'd0);
  assign stream_data = buf_mem[rd_ptr_reg];

  // Source cannot be stalled, so a full buffer drops the word and flags it
  always_comb begin
    buf_mem_next = buf_mem;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next = cnt_reg;
    if (push) begin
      buf_mem_next[wr_ptr_reg] = {top_reg, chroma_reg, luma_reg};
      wr_ptr_next = !wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = !rd_ptr_reg;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'd1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'd1;
    end
  end

  // Buffer storage and pointers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'd0;
    end else begin
      buf_mem <= buf_mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
    end
  end

  // ---------------- Avalon-MM slave ----------------
  logic req, wr_take;
  logic [3:0] idx;
  assign req = avs_read || avs_write;
  assign idx = avs_address[5:2];
  // One wait cycle on every access, answer at the second edge
  // A fixed answer time means a master never sees an unbounded stall;
  // read data is captured at the first edge and stands at the second
  assign avs_waitrequest = req && !ack_reg;
  assign wr_take = avs_write && ack_reg;
  assign avs_readdata = rdata_reg;

  always_comb begin
    ctrl_next = ctrl_reg;
    vwin_next = vwin_reg;
    hwin_next = hwin_reg;
    still_out_next = still_out_reg;
    still_in_next = still_in_reg;
    ack_next = req && !ack_reg;
    rdata_next = rdata_reg;
    // Overflow is sticky; a drop in the clearing cycle keeps it set
    // It marks only words the source lost, never a stall the buffer covered
    ovf_next = ovf_reg;
    if (avs_read && ack_reg && idx == VFIS_IDX_STATUS) begin
      ovf_next = 1'b0;
    end
    if (take_word && !buf_ready) begin
      ovf_next = 1'b1;
    end
    // Still decompression fetches pixels from the bus on each qualified rise
    // The last capture stands until the next one; software polls it
    if (mode == VFIS_MODE_STILL_DECOMP && rise_en) begin
      still_in_next = {hi_s, chroma_s, luma_s};
    end
    if (wr_take) begin
      unique case (idx)
        VFIS_IDX_CTRL: ctrl_next = avs_writedata[VFIS_CTRL_W-1:0];
        VFIS_IDX_VWIN: vwin_next = avs_writedata & 32'h03FF03FF;
        VFIS_IDX_HWIN: hwin_next = avs_writedata & 32'h03FF03FF;
        VFIS_IDX_STILL_OUT: still_out_next = avs_writedata[23:0];
        default: ;
      endcase
    end
    if (avs_read && !ack_reg) begin
      unique case (idx)
        VFIS_IDX_CTRL: rdata_next = {23'h0, ctrl_reg};
        VFIS_IDX_VWIN: rdata_next = vwin_reg;
        VFIS_IDX_HWIN: rdata_next = hwin_reg;
        VFIS_IDX_STATUS: rdata_next = {14'h0, ovf_reg, top_reg, 6'h0, line_cnt_reg};
        VFIS_IDX_STILL_OUT: rdata_next = {8'h00, still_out_reg};
        VFIS_IDX_STILL_IN: rdata_next = {8'h00, still_in_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Register bank; control resets with top sense set, windows fully open
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg <= VFIS_CTRL_RESET;
      vwin_reg <= {6'h00, VFIS_WIN_LAST_RESET, 6'h00, VFIS_WIN_FIRST_RESET};
      hwin_reg <= {6'h00, VFIS_WIN_LAST_RESET, 6'h00, VFIS_WIN_FIRST_RESET};
      still_out_reg <= 24'h000000;
      still_in_reg <= 24'h000000;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      ovf_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      vwin_reg <= vwin_next;
      hwin_reg <= hwin_next;
      still_out_reg <= still_out_next;
      still_in_reg <= still_in_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      ovf_reg <= ovf_next;
    end
  end
endmodule

// ---- bench/vfis_sampler_asserts.sv ----
`timescale 1ns/10ps
module vfis_sampler_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [vfis_pkg::VFIS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic hsync_oe_n,
  input wire logic vsync_oe_n,
  input wire logic ext_bus_oe_n,
  input wire logic [vfis_pkg::VFIS_WORD_W-1:0] stream_data,
  input wire logic stream_valid,
  input wire logic stream_ready
);
  import vfis_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [8:0] ctrl_reg;
  logic [8:0] ctrl_next;
  logic req;
  logic done;
  logic [2:0] mode;
  logic sync_drv;
  // Shadow of the control word, so pin ownership can be judged
  always_comb begin
    ctrl_next = ctrl_reg;
    if (done && avs_write && avs_address[5:2] == VFIS_IDX_CTRL) begin
      ctrl_next = avs_writedata[8:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    ctrl_reg <= sys_rst ? VFIS_CTRL_RESET : ctrl_next;
  end
  // Compression and MPEG ignore the internal sync bit
  assign req = avs_read || avs_write;
  assign done = req && !avs_waitrequest;
  assign mode = ctrl_reg[2:0];
  assign sync_drv = (mode == 3'h2 && ctrl_reg[3]) || mode == 3'h4 || mode == 3'h5;
  a_wait_single: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait too long");
  a_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("wait without request");
  a_unmapped_zero: assert property (done && avs_read && avs_address[5:2] > VFIS_IDX_STILL_IN
    |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (done && avs_read && avs_address[5:2] == VFIS_IDX_CTRL
    |-> avs_readdata == {23'h000000, ctrl_reg}) else $error("control readback wrong");
  a_stream_hold: assert property (stream_valid && !stream_ready
    |=> stream_valid && $stable(stream_data)) else $error("stream word lost");
  a_ext_bus_turn: assert property (ext_bus_oe_n == (mode != 3'h4))
    else $error("wide bus enable wrong");
  a_sync_turn: assert property (hsync_oe_n == !sync_drv && vsync_oe_n == !sync_drv)
    else $error("sync enable wrong");
  a_push_mode: assert property ($rose(stream_valid) |-> mode inside {3'h1, 3'h2, 3'h3})
    else $error("word pushed in wrong mode");
  a_reset_quiet: assert property ($past(sys_rst)
    |-> hsync_oe_n && vsync_oe_n && ext_bus_oe_n && !stream_valid) else $error("not quiet");
endmodule
bind vfis_sampler vfis_sampler_asserts u_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .hsync_oe_n(hsync_oe_n), .vsync_oe_n(vsync_oe_n),
  .ext_bus_oe_n(ext_bus_oe_n), .stream_data(stream_data), .stream_valid(stream_valid),
  .stream_ready(stream_ready));

// ---- bench/vfis_video_src.sv ----
`timescale 1ns/10ps
module vfis_video_src #(
  parameter int FRAMES = 2
) (
  input wire logic start,
  input wire logic inv,
  input wire logic qpol,
  input wire logic fi_level,
  output logic busy,
  output logic dclk,
  output logic qual,
  output logic [7:0] luma,
  output logic [7:0] chroma,
  output logic hs,
  output logic vs,
  output logic fi
);
  localparam int LINE_LEN = 8;
  localparam int FRAME_LINES = 6;
  int t;
  int k;
  int ln;
  // Clock stands still between runs; a run opens one sample before vsync
  initial begin
    {busy, dclk, qual, luma, chroma, hs, vs, fi} = '0;
    forever begin
      @(posedge start);
      busy = 1'b1;
      for (t = LINE_LEN / 2 - 1; t < LINE_LEN / 2 + FRAMES * FRAME_LINES * LINE_LEN; t++) begin
        k = t % LINE_LEN;
        ln = (t / LINE_LEN) % FRAME_LINES;
        luma = 8'(k);
        chroma = 8'(ln);
        hs = (k < 2) ^ inv;
        vs = ((ln == 0 && k >= 4) || (ln == 1 && k < 4)) ^ inv;
        fi = fi_level;
        qual = qpol;
        #80 dclk = 1'b1;
        #80 dclk = 1'b0;
        // Junk on the other rise exposes a sampler taking the wrong edge
        {luma, chroma, hs, vs, fi} = ~{luma, chroma, hs, vs, fi};
        qual = !qpol;
        #80 dclk = 1'b1;
        #80 dclk = 1'b0;
      end
      busy = 1'b0;
    end
  end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import vfis_pkg::*;
  localparam int LINE_LEN = 8;
  localparam int FRAME_LINES = 6;
  localparam int FRAMES = 2;
  localparam logic [8:0] PASS_CTRL [3] = '{9'h121, 9'h0DB, 9'h1E2};
  logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [VFIS_ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic dclk, qual, hs, vs, fi, gen_hs, gen_vs, svalid, sready, ext_oe_n;
  logic [7:0] luma, chroma, ext_hi;
  logic [23:0] ext_out;
  logic [16:0] sdata;
  logic src_start, src_inv, src_qpol, src_fi, src_busy;
  int err_count;
  int n_compared;
  logic [31:0] rd_q[$];
  logic [16:0] px_q[$];
  vfis_sampler dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .double_rate_pixel_clock(dclk), .pixel_clock_qualifier(qual), .luma_bus(luma),
    .chroma_bus(chroma), .ext_bus_hi_in(ext_hi), .hsync_in(hs), .vsync_in(vs),
    .field_indicator_input(fi), .hsync_out(), .hsync_oe_n(), .vsync_out(), .vsync_oe_n(),
    .ext_bus_out(ext_out), .ext_bus_oe_n(ext_oe_n), .gen_hsync(gen_hs), .gen_vsync(gen_vs),
    .stream_data(sdata), .stream_valid(svalid), .stream_ready(sready));
  vfis_video_src #(.FRAMES(FRAMES)) u_src (.start(src_start), .inv(src_inv), .qpol(src_qpol),
    .fi_level(src_fi), .busy(src_busy), .dclk(dclk), .qual(qual), .luma(luma),
    .chroma(chroma), .hs(hs), .vs(vs), .fi(fi));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
      err_count++;
    end
  endtask
  task stop_test;
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One Avalon transfer; an edge passes after release so requests never merge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest) @(posedge clk_sys);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Random window, two frames, expected words noted before the source runs
  task automatic pass(input logic [8:0] c);
    int fl, ll, fp, lp, n;
    logic f, top;
    fl = 1 + $urandom % 3;
    ll = fl + $urandom % (FRAME_LINES - fl);
    fp = $urandom % LINE_LEN;
    lp = fp + $urandom % (LINE_LEN - fp);
    f = 1'($urandom);
    top = c[4] ? f == c[5] : c[6] == c[5];
    src_fi <= f;
    src_inv <= c[6];
    src_qpol <= c[8];
    bus(1'b1, 6'h04, 32'(ll) << 16 | 32'(fl));
    bus(1'b1, 6'h08, 32'(lp) << 16 | 32'(fp));
    bus(1'b1, 6'h00, {23'h000000, c});
    rd(6'h00, {23'h000000, c});
    repeat (FRAMES) for (int ln = fl; ln <= ll; ln++) for (int k = fp; k <= lp; k++)
      px_q.push_back({top, 8'(ln), 8'(k)});
    src_start <= 1'b1;
    @(posedge clk_sys);
    src_start <= 1'b0;
    @(posedge clk_sys);
    n = 0;
    while ((src_busy || px_q.size() > 0) && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    check(32'(px_q.size()), 32'h0);
    bus(1'b1, 6'h00, 32'h20);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    stop_test;
  end
  // Free-running random inputs, including receiver stalls
  always @(posedge clk_sys) begin
    sready <= 1'($urandom);
    gen_hs <= 1'($urandom);
    gen_vs <= 1'($urandom);
    ext_hi <= 8'($urandom);
  end
  // Each result is paired with the oldest note when it appears
  always @(posedge clk_sys) begin
    if (avs_read && !avs_waitrequest)
      check(avs_readdata, rd_q.size() ? rd_q.pop_front() : 32'hX);
    if (svalid && sready)
      check({15'h0, sdata}, px_q.size() ? {15'h0, px_q.pop_front()} : 32'hX);
  end
  initial begin
    logic [31:0] d;
    {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {src_start, src_inv, src_qpol, src_fi} = '0;
    sys_rst = 1'b1;
    void'($urandom(48));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(6'h00, 32'h0000_0020);
    rd(6'h04, 32'h03FF_0000);
    rd(6'h08, 32'h03FF_0000);
    bus(1'b1, 6'h38, 32'hFFFF_FFFF);
    rd(6'h38, 32'h0000_0000);
    foreach (PASS_CTRL[i]) pass(PASS_CTRL[i]);
    bus(1'b1, 6'h00, 32'h3B);
    bus(1'b1, 6'h00, 32'h0A);
    d = $urandom;
    bus(1'b1, 6'h10, d);
    bus(1'b1, 6'h00, 32'h24);
    @(negedge clk_sys);
    check({8'h00, ext_out}, {8'h00, d[23:0]});
    check({31'h0, ext_oe_n}, 32'h0);
    @(posedge clk_sys);
    bus(1'b1, 6'h00, 32'h25);
    @(negedge clk_sys);
    check({31'h0, ext_oe_n}, 32'h1);
    @(posedge clk_sys);
    bus(1'b1, 6'h00, 32'h20);
    stop_test;
  end
endmodule
